// ==== inc/rif_regs.svh ====
// Register offsets, field positions, reset values and timing counts of the interrupt status block.
`ifndef RIF_REGS_SVH
`define RIF_REGS_SVH

`define RIF_ADDR_W 5
`define RIF_STAT_ADDR 5'h0c
`define RIF_MASK_ADDR 5'h0d
`define RIF_STAT_RST 8'h00
`define RIF_MASK_RST 8'h3e

`define RIF_B_TX 7
`define RIF_B_SRX 6
`define RIF_B_FIFO 5
`define RIF_B_CRC 4
`define RIF_B_PAR 3
`define RIF_B_FRM 2
`define RIF_B_COL 1
`define RIF_B_NORESP 0

`define RIF_COL_THR_LO 4'h6
`define RIF_COL_THR_HI 4'h7

`define RIF_CLK_MHZ 100
`define RIF_COL_KBPS 106
`define RIF_BIT_CYC ((`RIF_CLK_MHZ * 1000) / `RIF_COL_KBPS)
`define RIF_NORESP_STEP_NS 1000
`define RIF_NORESP_STEP_CYC ((`RIF_NORESP_STEP_NS * `RIF_CLK_MHZ) / 1000)

`endif

// ==== inc/rif_pkg.sv ====
// Types shared by the interrupt status block and its collision counter.
package rif_pkg;

	typedef enum logic [1:0] {
		RIF_PROTO_14443A = 2'h0,
		RIF_PROTO_15693 = 2'h1,
		RIF_PROTO_OTHER = 2'h2
	} rif_proto_t;

	typedef enum logic [3:0] {
		RIF_ST_IDLE = 4'h1,
		RIF_ST_TX = 4'h2,
		RIF_ST_RX = 4'h4,
		RIF_ST_WAIT = 4'h8
	} rif_state_t;

	typedef struct packed {
		logic tx_start;
		logic tx_done;
		logic rx_sof;
		logic rx_done;
		logic crc_err;
		logic parity_err;
		logic framing_err;
	} rif_evt_t;

	typedef struct packed {
		rif_proto_t proto;
		logic rx_crc_off;
		logic single_sub;
		logic col_thr_hi;
		logic [7:0] noresp_wait;
		logic [6:0] fifo_hi_lvl;
		logic [6:0] fifo_lo_lvl;
	} rif_cfg_t;

endpackage

// ==== core/rif_edge_cnt.sv ====
// Counts subcarrier edges within one bit period and flags a collision.
`timescale 1ns/1ps
`include "rif_regs.svh"

module rif_edge_cnt import rif_pkg::*; #(
	parameter int BIT_CYC = `RIF_BIT_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic sub_pin,
	input wire logic enable,
	input wire logic thr_hi,
	output logic coll
);

	logic sync1_r;
	logic sync2_r;
	logic prev_r;
	logic [15:0] per_cnt_r;
	logic [15:0] per_cnt_nxt;
	logic [3:0] edge_cnt_r;
	logic [3:0] edge_cnt_nxt;
	logic coll_r;
	logic coll_nxt;
	logic sub_edge;
	logic per_end;
	logic [3:0] thr;

	// Noise on the pin counts like a real tag edge; nothing filters it.
	assign sub_edge = enable & (sync2_r ^ prev_r);
	assign per_end = (per_cnt_r == 16'(BIT_CYC - 1));
	assign thr = thr_hi ? `RIF_COL_THR_HI : `RIF_COL_THR_LO;
	assign per_cnt_nxt = (!enable || per_end) ? 16'h0000 : per_cnt_r + 16'h0001;
	assign edge_cnt_nxt = (!enable || per_end) ? 4'h0 :
		(sub_edge && edge_cnt_r != 4'hf) ? edge_cnt_r + 4'h1 : edge_cnt_r;
	// One pulse per bit period that sees more edges than the threshold.
	assign coll_nxt = enable & per_end & (edge_cnt_r > thr);
	assign coll = coll_r;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			prev_r <= 1'b0;
		end else begin
			sync1_r <= sub_pin;
			sync2_r <= sync1_r;
			prev_r <= sync2_r;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			per_cnt_r <= 16'h0000;
			edge_cnt_r <= 4'h0;
			coll_r <= 1'b0;
		end else begin
			per_cnt_r <= per_cnt_nxt;
			edge_cnt_r <= edge_cnt_nxt;
			coll_r <= coll_nxt;
		end
	end

endmodule

// ==== core/rif_irq_status.sv ====
// Interrupt cause flags, interrupt mask and interrupt request line of the reader front end.
`timescale 1ns/1ps
`include "rif_regs.svh"

//
// Contract
// - Bit7 set at TX start, IRQ at end
// - Bit6 set at SOF, IRQ at end
// - Bit5 on FIFO threshold crossing
// - Bit4 CRC error unless CRC disabled
// - Bit3 parity error in 14443 A
// - Bit2 framing or EOF error
// - Bit1 when edges exceed 6/7 per bit
// - Noise may also raise collision flag
// - Bit0 no response timeout, 15693 only
// - Status read clears flags and IRQ
// - TX disables decoder, only bits 5,7
// - RX changes only bit6, IRQ delayed
// - IRQ raised at TX and RX end
// - Status zero at reset and after read; a flag set in the cycle of the read survives it
// - Mask enables bits 5..0, reset 0x3E
module rif_irq_status import rif_pkg::*; #(
	parameter int BIT_CYC = `RIF_BIT_CYC,
	parameter int NORESP_STEP_CYC = `RIF_NORESP_STEP_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic reg_rd,
	input wire logic reg_wr,
	input wire logic [`RIF_ADDR_W-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire rif_evt_t evt,
	input wire rif_cfg_t cfg,
	input wire logic [6:0] fifo_level,
	input wire logic sub_pin,
	output logic irq,
	output logic decoder_en
);

	rif_state_t state_r;
	rif_state_t state_nxt;
	logic [7:0] stat_r;
	logic [7:0] stat_nxt;
	logic [7:0] mask_r;
	logic [7:0] mask_nxt;
	logic [5:0] pend_r;
	logic [5:0] pend_nxt;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic irq_r;
	logic irq_nxt;
	logic dec_en_r;
	logic fifo_hi_r;
	logic fifo_lo_r;
	logic [7:0] unit_cnt_r;
	logic [7:0] unit_cnt_nxt;
	logic [15:0] step_cnt_r;
	logic [15:0] step_cnt_nxt;

	logic in_tx;
	logic in_rx;
	logic in_wait;
	logic end_tx;
	logic end_rx;
	logic rd_stat;
	logic rd_mask;
	logic wr_mask;
	logic fifo_hi;
	logic fifo_lo;
	logic fifo_set;
	logic crc_fail_flag;
	logic parity_fail_flag;
	logic framing_fail_flag;
	logic col_flag;
	logic col_en;
	logic step_end;
	logic timeout;
	logic noresp_flag;
	logic tx_set;
	logic sof_set;
	logic [5:0] low_now;
	logic [5:0] low_apply;
	logic [7:0] set_vec;
	logic raise;

	function automatic logic addr_hit(input logic [`RIF_ADDR_W-1:0] a,
			input logic [`RIF_ADDR_W-1:0] b);
		addr_hit = (a == b);
	endfunction

	// Register port decode.
	assign rd_stat = reg_rd & addr_hit(reg_addr, `RIF_STAT_ADDR);
	assign rd_mask = reg_rd & addr_hit(reg_addr, `RIF_MASK_ADDR);
	assign wr_mask = reg_wr & addr_hit(reg_addr, `RIF_MASK_ADDR);

	// Phase decode.
	assign in_tx = (state_r == RIF_ST_TX);
	assign in_rx = (state_r == RIF_ST_RX);
	assign in_wait = (state_r == RIF_ST_WAIT);
	assign end_tx = in_tx & evt.tx_done;
	assign end_rx = in_rx & evt.rx_done;

	// Threshold crossing is caught on the edge of each comparison, so a level that
	// sits at a threshold does not retrigger the flag after every read.
	assign fifo_hi = (fifo_level >= cfg.fifo_hi_lvl);
	assign fifo_lo = (fifo_level <= cfg.fifo_lo_lvl);
	assign fifo_set = (fifo_hi & ~fifo_hi_r) | (fifo_lo & ~fifo_lo_r);

	// Error sources with their protocol qualifiers.
	assign crc_fail_flag = evt.crc_err & ~cfg.rx_crc_off;
	assign parity_fail_flag = evt.parity_err & (cfg.proto == RIF_PROTO_14443A);
	assign framing_fail_flag = evt.framing_err;
	assign col_en = in_rx & ((cfg.proto == RIF_PROTO_14443A) |
		((cfg.proto == RIF_PROTO_15693) & cfg.single_sub));

	rif_edge_cnt #(
		.BIT_CYC(BIT_CYC)
	) u_edge_cnt (
		.clk(clk),
		.rst(rst),
		.sub_pin(sub_pin),
		.enable(col_en),
		.thr_hi(cfg.col_thr_hi),
		.coll(col_flag)
	);

	// No-response timer runs in the gap after a transmission.
	assign step_end = (step_cnt_r == 16'(NORESP_STEP_CYC - 1));
	assign timeout = in_wait & (unit_cnt_r == 8'h00);
	assign noresp_flag = timeout & (cfg.proto == RIF_PROTO_15693);
	assign unit_cnt_nxt = end_tx ? cfg.noresp_wait :
		(in_wait && step_end && unit_cnt_r != 8'h00) ? unit_cnt_r - 8'h01 : unit_cnt_r;
	assign step_cnt_nxt = (!in_wait || step_end) ? 16'h0000 : step_cnt_r + 16'h0001;

	// Phase sequencing.
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			RIF_ST_IDLE: begin
				if (evt.tx_start) begin
					state_nxt = RIF_ST_TX;
				end else if (evt.rx_sof) begin
					state_nxt = RIF_ST_RX;
				end
			end
			RIF_ST_TX: begin
				if (evt.tx_done) begin
					state_nxt = RIF_ST_WAIT;
				end
			end
			RIF_ST_RX: begin
				if (evt.rx_done) begin
					state_nxt = RIF_ST_IDLE;
				end
			end
			RIF_ST_WAIT: begin
				if (evt.tx_start) begin
					state_nxt = RIF_ST_TX;
				end else if (evt.rx_sof) begin
					state_nxt = RIF_ST_RX;
				end else if (timeout) begin
					state_nxt = RIF_ST_IDLE;
				end
			end
			default: begin
				state_nxt = RIF_ST_IDLE;
			end
		endcase
	end

	// Flag sources gathered by bit position.
	assign tx_set = evt.tx_start & ~in_rx;
	assign sof_set = evt.rx_sof & ~in_tx & ~in_rx;
	assign low_now = {fifo_set, crc_fail_flag, parity_fail_flag, framing_fail_flag,
		col_flag, noresp_flag};

	// During transmit the decoder is off, so only the FIFO flag may move besides
	// the transmit flag. During receive the low flags wait in a shadow until the
	// frame ends, which keeps receive-start the only visible change.
	assign low_apply = in_tx ? {low_now[5], 5'h00} :
		in_rx ? (end_rx ? (pend_r | low_now) : 6'h00) : low_now;
	assign pend_nxt = (!in_rx || end_rx) ? 6'h00 : (pend_r | low_now);
	assign set_vec = {tx_set, sof_set, low_apply};

	// A set in the cycle of the clearing read survives it; older flags stay until
	// that read.
	assign stat_nxt = (rd_stat ? `RIF_STAT_RST : stat_r) | set_vec;

	// Transmit and receive starts never interrupt at once; their phase end does.
	// Other sources interrupt through their enable bit when not receiving.
	assign raise = end_tx | end_rx |
		(|(low_apply & mask_r[5:0] & {6{~in_rx}}));
	assign irq_nxt = raise | (irq_r & ~rd_stat);

	assign mask_nxt = wr_mask ? reg_wdata : mask_r;
	assign rdata_nxt = rd_stat ? stat_r : rd_mask ? mask_r : reg_rd ? 8'h00 : rdata_r;

	assign reg_rdata = rdata_r;
	assign irq = irq_r;
	assign decoder_en = dec_en_r;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r <= RIF_ST_IDLE;
			dec_en_r <= 1'b1;
			pend_r <= 6'h00;
		end else begin
			state_r <= state_nxt;
			dec_en_r <= (state_nxt != RIF_ST_TX);
			pend_r <= pend_nxt;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stat_r <= `RIF_STAT_RST;
			mask_r <= `RIF_MASK_RST;
			irq_r <= 1'b0;
			rdata_r <= 8'h00;
		end else begin
			stat_r <= stat_nxt;
			mask_r <= mask_nxt;
			irq_r <= irq_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fifo_hi_r <= 1'b0;
			fifo_lo_r <= 1'b0;
			unit_cnt_r <= 8'h00;
			step_cnt_r <= 16'h0000;
		end else begin
			fifo_hi_r <= fifo_hi;
			fifo_lo_r <= fifo_lo;
			unit_cnt_r <= unit_cnt_nxt;
			step_cnt_r <= step_cnt_nxt;
		end
	end

endmodule

// ==== tb/rif_irq_status_asserts.sv ====
// Concurrent checks on the ports of the interrupt status block.
`timescale 1ns/1ps
`include "rif_regs.svh"
module rif_irq_status_asserts import rif_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic reg_rd,
	input wire logic [`RIF_ADDR_W-1:0] reg_addr,
	input wire logic [7:0] reg_rdata,
	input wire rif_evt_t evt,
	input wire logic [6:0] fifo_level,
	input wire logic irq,
	input wire logic decoder_en
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire rd_stat = reg_rd && reg_addr == `RIF_STAT_ADDR;
	// A moving FIFO level can raise the line on its own, so quiet cycles demand a steady level.
	sequence no_cause_s;
		evt == '0 && $stable(fifo_level);
	endsequence
	sequence tx_end_s;
		!decoder_en ##0 evt.tx_done;
	endsequence
	reset_vals_a: assert property (disable iff (1'b0) rst |-> !irq && reg_rdata == 8'h00)
		else $error("outputs not cleared in reset");
	rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved without a read");
	irq_hold_a: assert property (irq && !rd_stat |=> irq)
		else $error("irq dropped without status read");
	read_clear_a: assert property (rd_stat ##0 no_cause_s |=> !irq)
		else $error("status read did not clear irq");
	tx_hold_a: assert property (!decoder_en && !evt.tx_done |=> !decoder_en)
		else $error("decoder enabled before transmit end");
	tx_end_irq_a: assert property (tx_end_s |=> decoder_en && irq)
		else $error("no irq after transmit end");
	tx_quiet_a: assert property (!decoder_en && !irq ##0 no_cause_s |=> !irq)
		else $error("irq raised during transmit");
	rx_sof_quiet_a: assert property (decoder_en && !irq && evt == 7'h10 ##0 $stable(fifo_level)
		|=> !irq)
		else $error("irq raised at receive start");
endmodule
bind rif_irq_status rif_irq_status_asserts i_rif_irq_status_asserts (.clk(clk), .rst(rst),
	.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata(reg_rdata), .evt(evt),
	.fifo_level(fifo_level), .irq(irq), .decoder_en(decoder_en));

// ==== tb/rif_host_model.sv ====
// Host side model that drives register read and write strobes.
`timescale 1ns/1ps
`include "rif_regs.svh"
module rif_host_model (
	input wire logic clk,
	output logic reg_rd,
	output logic reg_wr,
	output logic [`RIF_ADDR_W-1:0] reg_addr,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata
);
	initial begin
		reg_rd = 1'b0;
		reg_wr = 1'b0;
		reg_addr = 5'h00;
		reg_wdata = 8'h00;
	end
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
		reg_wdata = ~d;
	endtask
	// The only acknowledge the block knows is a status read, so the host reads after each irq.
	task automatic rd(input logic [4:0] a, output logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		d = reg_rdata;
	endtask
endmodule

// ==== tb/rif_irq_status_tb_top.sv ====
// Directed testbench of the interrupt status block.
`timescale 1ns/1ps
module rif_irq_status_tb_top import rif_pkg::*;;
	logic clk, rst, reg_rd, reg_wr, sub_pin, irq, decoder_en;
	logic [4:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata;
	logic [6:0] fifo_level;
	rif_evt_t evt;
	rif_cfg_t cfg;
	int n_mismatch, n_compared, n_cyc;
	rif_irq_status #(.BIT_CYC(16), .NORESP_STEP_CYC(2)) i_rif_irq_status (.clk(clk), .rst(rst),
		.reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .evt(evt), .cfg(cfg), .fifo_level(fifo_level),
		.sub_pin(sub_pin), .irq(irq), .decoder_en(decoder_en));
	rif_host_model i_rif_host_model (.clk(clk), .reg_rd(reg_rd), .reg_wr(reg_wr),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
	always #5 clk = ~clk;
	task automatic final_report;
		if (n_mismatch == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t byte %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t flag %b expected %b", $time, got, exp);
		end
	endtask
	task automatic rdc(input logic [4:0] a, input logic [7:0] exp);
		logic [7:0] d;
		i_rif_host_model.rd(a, d);
		chk8(d, exp);
	endtask
	task automatic pulse(input rif_evt_t e);
		@(negedge clk);
		evt = e;
		@(negedge clk);
		evt = '0;
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask
	always @(posedge clk) begin
		n_cyc++;
		if (n_cyc == 2000) begin
			n_mismatch++;
			final_report;
		end
	end
	initial begin
		clk = 1'b0;
		// Raised in the update region so every flip-flop already waits on its reset edge.
		rst <= 1'b1;
		evt = '0;
		cfg = '0;
		cfg.noresp_wait = 8'h04;
		cfg.fifo_hi_lvl = 7'h60;
		cfg.fifo_lo_lvl = 7'h04;
		fifo_level = 7'h10;
		sub_pin = 1'b0;
		idle(2);
		rst = 1'b0;
		rdc(5'h0c, 8'h00);
		rdc(5'h0d, 8'h3e);
		i_rif_host_model.wr(5'h0c, 8'hff);
		rdc(5'h0c, 8'h00);
		rdc(5'h1f, 8'h00);
		pulse(7'h40);
		chk1(decoder_en, 1'b0);
		pulse(7'h07);
		chk1(irq, 1'b0);
		pulse(7'h20);
		chk1(irq, 1'b1);
		chk1(decoder_en, 1'b1);
		rdc(5'h0c, 8'h80);
		chk1(irq, 1'b0);
		idle(12);
		rdc(5'h0c, 8'h00);
		pulse(7'h10);
		pulse(7'h07);
		// Fourteen edges back to back put more than six into the first bit window.
		repeat (14) @(negedge clk) sub_pin = ~sub_pin;
		idle(4);
		chk1(irq, 1'b0);
		pulse(7'h08);
		chk1(irq, 1'b1);
		rdc(5'h0c, 8'h5e);
		cfg.rx_crc_off = 1'b1;
		cfg.proto = RIF_PROTO_OTHER;
		pulse(7'h10);
		pulse(7'h07);
		pulse(7'h08);
		rdc(5'h0c, 8'h44);
		cfg.proto = RIF_PROTO_14443A;
		fifo_level = 7'h70;
		idle(3);
		chk1(irq, 1'b1);
		rdc(5'h0c, 8'h20);
		i_rif_host_model.wr(5'h0d, 8'h00);
		fifo_level = 7'h02;
		idle(3);
		chk1(irq, 1'b0);
		rdc(5'h0c, 8'h20);
		fifo_level = 7'h10;
		cfg.proto = RIF_PROTO_15693;
		i_rif_host_model.wr(5'h0d, 8'h01);
		pulse(7'h40);
		pulse(7'h20);
		idle(20);
		rdc(5'h0c, 8'h81);
		// Seven edges sit at the higher threshold and pass; eight exceed it.
		cfg.col_thr_hi = 1'b1;
		cfg.single_sub = 1'b1;
		for (int n = 7; n <= 8; n++) begin
			pulse(7'h10);
			repeat (n) @(negedge clk) sub_pin = ~sub_pin;
			idle(10);
			pulse(7'h08);
			rdc(5'h0c, (n == 8) ? 8'h42 : 8'h40);
		end
		final_report;
	end
endmodule
